// ---- design/aigh_pkg.sv ----
/*
 * Shared constants, types and decode helpers for the record amplifier
 * gain and headset register slice.
 * Assumes an 8-bit register port already decoded from the control bus.
 */
package aigh_pkg;

	// register offsets on the control port
	localparam logic [7:0] AIGH_OFS_RSVD  = 8'h0d;
	localparam logic [7:0] AIGH_OFS_DRV   = 8'h0e;
	localparam logic [7:0] AIGH_OFS_LGAIN = 8'h0f;
	localparam logic [7:0] AIGH_OFS_RGAIN = 8'h10;
	localparam logic [7:0] AIGH_OFS_LMIX  = 8'h11;

	// reset values
	localparam logic [7:0] AIGH_RST_RSVD  = 8'h00;
	localparam logic [7:0] AIGH_RST_DRV   = 8'h00;
	localparam logic [7:0] AIGH_RST_GAIN  = 8'h80;
	localparam logic [7:0] AIGH_RST_LMIX  = 8'hff;
	localparam logic [7:0] AIGH_RD_UNMAP  = 8'h00;

	// field positions
	localparam int AIGH_BIT_AC   = 7;
	localparam int AIGH_BIT_FD   = 6;
	localparam int AIGH_BIT_HS   = 4;
	localparam int AIGH_BIT_PD   = 3;
	localparam int AIGH_BIT_MUTE = 7;

	// writable bits of the driver register; the rest, except headset bit 4, read back as zero
	localparam logic [7:0] AIGH_DRV_WMASK = 8'hc8;

	// gain and level codes
	localparam logic [6:0] AIGH_GAIN_SAT  = 7'h77;
	localparam logic [3:0] AIGH_LEVEL_MAX = 4'h8;
	localparam logic [3:0] AIGH_LEVEL_OFF = 4'hf;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} aigh_req_t;

	// atten counts 1.5 dB steps below 0 dB
	typedef struct packed {
		logic       connect;
		logic [3:0] atten;
	} aigh_level_t;

	// reserved codes are treated as disconnected
	function automatic aigh_level_t aigh_level_dec(input logic [3:0] code);
		aigh_level_t l;
		l.connect = (code <= AIGH_LEVEL_MAX);
		l.atten   = l.connect ? code : 4'h0;
		return l;
	endfunction

endpackage

// ---- design/aigh_gain_dec.sv ----
/*
 * Registered saturating decode of a 7-bit record amplifier gain code into
 * half-dB steps above 0 dB.
 * Assumes the code comes from a register in the same clock domain.
 */
`timescale 1ns/10ps
module aigh_gain_dec
	import aigh_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic [6:0] code,
	output logic      [6:0] half_db
);

	logic [6:0] half_db_reg;
	logic [6:0] half_db_next;

	// codes above the top step all give the top step
	always_comb begin
		half_db_next = (code > AIGH_GAIN_SAT) ? AIGH_GAIN_SAT : code;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			half_db_reg <= 7'h00;
		end else begin
			half_db_reg <= half_db_next;
		end
	end

	assign half_db = half_db_reg;

endmodule

// ---- design/aigh_regs.sv ----
/*
 * Register slice for the record path: reserved filler, output driver and
 * headset status, left and right record amplifier mute and gain, and the
 * second-input level routing into the left record amplifier mix.
 * Assumes the control bus front end presents one-cycle read or write
 * strobes synchronous to CLK, and a headset detector level on HEADSET_IN.
 */
// What this block does
// RULE1: host writes only zero to reserved filler
// RULE2: bit 7 selects ac-coupled high-power drive
// RULE3: bit 6 flags fully differential output
// RULE4: bit 3 flags pseudodifferential output
// RULE5: host never sets bits 6 and 3
// RULE6: read-only bit 4 reports headset detected
// RULE7: reserved driver bits read zero, written zero
// RULE8: left amplifier muted while bit 7 set
// RULE9: right amplifier muted while bit 7 set
// RULE10: left gain half-dB steps, saturates 59.5 dB
// RULE11: right gain half-dB steps, saturates 59.5 dB
// RULE12: upper nibble sets second left input level
// RULE13: lower nibble sets second right input level
// RULE14: host never writes reserved level codes
`timescale 1ns/10ps
module aigh_regs
	import aigh_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        NRST,
	input  wire aigh_req_t   REQ,
	input  wire logic        HEADSET_IN,
	output logic      [7:0]  RD_DATA,
	output logic             RD_VALID,
	output logic             HP_AC_COUPLED,
	output logic             OUT_FULL_DIFF,
	output logic             OUT_PSEUDO_DIFF,
	output logic             LEFT_AMP_MUTE,
	output logic             RIGHT_AMP_MUTE,
	output logic      [6:0]  LEFT_AMP_GAIN,
	output logic      [6:0]  RIGHT_AMP_GAIN,
	output aigh_level_t      SECOND_LEFT_INPUT_LVL,
	output aigh_level_t      SECOND_RIGHT_INPUT_LVL
);

	// one-hot offset hit, shared by the write and read paths
	typedef struct packed {
		logic rsvd;
		logic drv;
		logic lgain;
		logic rgain;
		logic lmix;
	} aigh_hit_t;

	logic [7:0]  rsvd_reg;
	logic [7:0]  rsvd_next;
	logic [7:0]  drv_reg;
	logic [7:0]  drv_next;
	logic        hs_reg;
	logic        hs_next;
	logic [7:0]  lgain_reg;
	logic [7:0]  lgain_next;
	logic [7:0]  rgain_reg;
	logic [7:0]  rgain_next;
	logic [7:0]  lmix_reg;
	logic [7:0]  lmix_next;
	logic [7:0]  rd_data_reg;
	logic [7:0]  rd_data_next;
	logic        rd_valid_reg;
	logic        rd_valid_next;
	aigh_level_t l2_reg;
	aigh_level_t l2_next;
	aigh_level_t r2_reg;
	aigh_level_t r2_next;
	logic [7:0]  drv_view;
	aigh_hit_t   hit;

	// unmapped offsets hit nothing, so writes there are dropped
	function automatic aigh_hit_t ofs_hit(input logic [7:0] addr);
		aigh_hit_t h;
		h = '0;
		if (addr == AIGH_OFS_RSVD) begin
			h.rsvd = 1'b1;
		end else if (addr == AIGH_OFS_DRV) begin
			h.drv = 1'b1;
		end else if (addr == AIGH_OFS_LGAIN) begin
			h.lgain = 1'b1;
		end else if (addr == AIGH_OFS_RGAIN) begin
			h.rgain = 1'b1;
		end else if (addr == AIGH_OFS_LMIX) begin
			h.lmix = 1'b1;
		end
		return h;
	endfunction

	always_comb begin
		hit = ofs_hit(REQ.addr);
	end

	// headset flag sits in bit 4, everything else masked to writable bits
	always_comb begin
		drv_view              = drv_reg & AIGH_DRV_WMASK; // RULE7
		drv_view[AIGH_BIT_HS] = hs_reg; // RULE6
	end

	// register writes
	always_comb begin
		rsvd_next  = rsvd_reg;
		drv_next   = drv_reg;
		lgain_next = lgain_reg;
		rgain_next = rgain_reg;
		lmix_next  = lmix_reg;
		if (REQ.wr) begin
			if (hit.rsvd) begin
				// stored as written; the host is expected to keep it zero
				rsvd_next = REQ.wdata; // RULE1
			end else if (hit.drv) begin
				// both output arrangement bits high is not filtered here
				drv_next = REQ.wdata & AIGH_DRV_WMASK; // RULE7
			end else if (hit.lgain) begin
				lgain_next = REQ.wdata;
			end else if (hit.rgain) begin
				rgain_next = REQ.wdata;
			end else if (hit.lmix) begin
				lmix_next = REQ.wdata;
			end
		end
	end

	// headset level is taken as synchronous and follows the detector
	always_comb begin
		hs_next = HEADSET_IN; // RULE6
	end

	// register reads, one cycle after the strobe
	always_comb begin
		rd_valid_next = REQ.rd;
		rd_data_next  = rd_data_reg;
		if (REQ.rd) begin
			if (hit.rsvd) begin
				rd_data_next = rsvd_reg;
			end else if (hit.drv) begin
				rd_data_next = drv_view;
			end else if (hit.lgain) begin
				rd_data_next = lgain_reg;
			end else if (hit.rgain) begin
				rd_data_next = rgain_reg;
			end else if (hit.lmix) begin
				rd_data_next = lmix_reg;
			end else begin
				rd_data_next = AIGH_RD_UNMAP;
			end
		end
	end

	// level fields decoded once into registered routing controls
	always_comb begin
		l2_next = aigh_level_dec(lmix_reg[7:4]); // RULE12
		r2_next = aigh_level_dec(lmix_reg[3:0]); // RULE13
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rsvd_reg  <= AIGH_RST_RSVD; // RULE1
			drv_reg   <= AIGH_RST_DRV;
			lgain_reg <= AIGH_RST_GAIN; // RULE8
			rgain_reg <= AIGH_RST_GAIN; // RULE9
			lmix_reg  <= AIGH_RST_LMIX;
		end else begin
			rsvd_reg  <= rsvd_next;
			drv_reg   <= drv_next;
			lgain_reg <= lgain_next;
			rgain_reg <= rgain_next;
			lmix_reg  <= lmix_next;
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			hs_reg <= 1'b0; // RULE6
		end else begin
			hs_reg <= hs_next;
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rd_data_reg  <= AIGH_RD_UNMAP;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_data_reg  <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
		end
	end

	// reset state matches the disconnected code held in the routing register
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			l2_reg <= '{connect: 1'b0, atten: 4'h0};
			r2_reg <= '{connect: 1'b0, atten: 4'h0};
		end else begin
			l2_reg <= l2_next;
			r2_reg <= r2_next;
		end
	end

	// gain decode adds one register stage behind the gain registers
	aigh_gain_dec u_left_gain (
		.clk     (CLK),
		.nrst    (NRST),
		.code    (lgain_reg[6:0]), // RULE10
		.half_db (LEFT_AMP_GAIN)
	);

	aigh_gain_dec u_right_gain (
		.clk     (CLK),
		.nrst    (NRST),
		.code    (rgain_reg[6:0]), // RULE11
		.half_db (RIGHT_AMP_GAIN)
	);

	assign RD_DATA                = rd_data_reg;
	assign RD_VALID               = rd_valid_reg;
	assign HP_AC_COUPLED          = drv_reg[AIGH_BIT_AC]; // RULE2
	assign OUT_FULL_DIFF          = drv_reg[AIGH_BIT_FD]; // RULE3
	assign OUT_PSEUDO_DIFF        = drv_reg[AIGH_BIT_PD]; // RULE4
	assign LEFT_AMP_MUTE          = lgain_reg[AIGH_BIT_MUTE]; // RULE8
	assign RIGHT_AMP_MUTE         = rgain_reg[AIGH_BIT_MUTE]; // RULE9
	assign SECOND_LEFT_INPUT_LVL  = l2_reg;
	assign SECOND_RIGHT_INPUT_LVL = r2_reg;

endmodule

// ---- tb/aigh_regs_monitor.sv ----
/* port assertions for aigh_regs; assumes one clock and async low reset */
`timescale 1ns/10ps
module aigh_regs_monitor
	import aigh_pkg::*;
(
	input wire logic        CLK,
	input wire logic        NRST,
	input wire aigh_req_t   REQ,
	input wire logic        HEADSET_IN,
	input wire logic [7:0]  RD_DATA,
	input wire logic        RD_VALID,
	input wire logic        HP_AC_COUPLED,
	input wire logic        OUT_FULL_DIFF,
	input wire logic        OUT_PSEUDO_DIFF,
	input wire logic        LEFT_AMP_MUTE,
	input wire logic        RIGHT_AMP_MUTE,
	input wire logic [6:0]  LEFT_AMP_GAIN,
	input wire logic [6:0]  RIGHT_AMP_GAIN,
	input wire aigh_level_t SECOND_LEFT_INPUT_LVL,
	input wire aigh_level_t SECOND_RIGHT_INPUT_LVL
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	sequence s_wr(a);
		REQ.wr && REQ.addr == a;
	endsequence
	chk_ac_mode: assert property (s_wr(AIGH_OFS_DRV) |=> HP_AC_COUPLED == $past(REQ.wdata[7]))
		else $error("ac mode");
	chk_full_diff: assert property (s_wr(AIGH_OFS_DRV) |=> OUT_FULL_DIFF == $past(REQ.wdata[6]))
		else $error("full diff");
	chk_pseudo_diff: assert property (s_wr(AIGH_OFS_DRV) |=> OUT_PSEUDO_DIFF == $past(REQ.wdata[3]))
		else $error("pseudo diff");
	chk_headset_read: assert property (REQ.rd && REQ.addr == AIGH_OFS_DRV |=>
		RD_DATA[4] == $past(HEADSET_IN, 2) && (RD_DATA & 8'h27) == 8'h00) else $error("headset read");
	chk_left_mute: assert property (s_wr(AIGH_OFS_LGAIN) |=> LEFT_AMP_MUTE == $past(REQ.wdata[7]))
		else $error("left mute");
	chk_right_mute: assert property (s_wr(AIGH_OFS_RGAIN) |=> RIGHT_AMP_MUTE == $past(REQ.wdata[7]))
		else $error("right mute");
	chk_left_gain: assert property (s_wr(AIGH_OFS_LGAIN) |=> ##1 LEFT_AMP_GAIN ==
		(($past(REQ.wdata[6:0], 2) > 7'h77) ? 7'h77 : $past(REQ.wdata[6:0], 2))) else $error("left gain");
	chk_left_level: assert property (REQ.wr && REQ.addr == AIGH_OFS_LMIX && REQ.wdata[7:4] <= 4'h8 |=>
		##1 SECOND_LEFT_INPUT_LVL == {1'b1, $past(REQ.wdata[7:4], 2)}) else $error("left level");
	chk_right_gain: assert property (s_wr(AIGH_OFS_RGAIN) |=> ##1 RIGHT_AMP_GAIN ==
		(($past(REQ.wdata[6:0], 2) > 7'h77) ? 7'h77 : $past(REQ.wdata[6:0], 2))) else $error("right gain");
	chk_right_level: assert property (REQ.wr && REQ.addr == AIGH_OFS_LMIX && REQ.wdata[3:0] <= 4'h8 |=>
		##1 SECOND_RIGHT_INPUT_LVL == {1'b1, $past(REQ.wdata[3:0], 2)}) else $error("right level");
	chk_left_off: assert property (REQ.wr && REQ.addr == AIGH_OFS_LMIX && REQ.wdata[7:4] == 4'hf |=>
		##1 !SECOND_LEFT_INPUT_LVL.connect) else $error("left level off");
	chk_read_valid: assert property (REQ.rd |=> RD_VALID) else $error("read valid");
	chk_valid_drop: assert property (!REQ.rd |=> !RD_VALID) else $error("valid drop");
endmodule
bind aigh_regs aigh_regs_monitor u_aigh_regs_monitor (.*);

// ---- tb/aigh_host.sv ----
/* host model on the register port; assumes it drives at falling CLK */
`timescale 1ns/10ps
module aigh_host
	import aigh_pkg::*;
(
	input wire logic       clk,
	input wire logic [7:0] rd_data,
	input wire logic       rd_valid,
	output aigh_req_t      req
);
	initial req = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (a == AIGH_OFS_RSVD)
			d = 8'h00;
		if (a == AIGH_OFS_DRV)
			d = d & 8'hc8 & ~{4'h0, d[6], 3'h0};
		@(negedge clk) req <= '{1'b1, 1'b0, a, d};
		@(negedge clk) req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [8:0] q);
		@(negedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk) req <= '0;
		// read answer stands for one cycle after the strobe edge
		q = {rd_valid, rd_data};
	endtask
endmodule

// ---- tb/tb.sv ----
/* self-checking bench for aigh_regs; assumes host model and bound monitor */
`timescale 1ns/10ps
module tb import aigh_pkg::*;;
	logic        CLK = 1'b0;
	logic        NRST = 1'b0;
	logic        HEADSET_IN = 1'b0;
	aigh_req_t   REQ;
	logic [7:0]  RD_DATA;
	logic        RD_VALID, HP_AC_COUPLED, OUT_FULL_DIFF, OUT_PSEUDO_DIFF, LEFT_AMP_MUTE, RIGHT_AMP_MUTE;
	logic [6:0]  LEFT_AMP_GAIN, RIGHT_AMP_GAIN;
	aigh_level_t SECOND_LEFT_INPUT_LVL, SECOND_RIGHT_INPUT_LVL;
	logic [8:0]  q;
	int          bad_count = 0;
	int          comparisons = 0;
	aigh_regs u_aigh_regs (.*);
	aigh_host u_aigh_host (.clk(CLK), .rd_data(RD_DATA), .rd_valid(RD_VALID), .req(REQ));
	initial forever #5 CLK = ~CLK;
	task automatic chk(input string n, input logic [8:0] got, input logic [8:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s exp %h got %h", n, exp, got);
		end
	endtask
	task automatic settle;
		repeat (2) @(posedge CLK);
		#1;
	endtask
	task automatic t_reset;
		logic [7:0] e [6] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'hff, 8'h00};
		chk("reset pins", {HP_AC_COUPLED, OUT_FULL_DIFF, OUT_PSEUDO_DIFF, LEFT_AMP_MUTE, RIGHT_AMP_MUTE}, 9'h003);
		chk("reset left gain", LEFT_AMP_GAIN, 9'h000);
		chk("reset right gain", RIGHT_AMP_GAIN, 9'h000);
		chk("reset levels", {SECOND_LEFT_INPUT_LVL, SECOND_RIGHT_INPUT_LVL}, 9'h000);
		for (int i = 0; i < 6; i++) begin
			u_aigh_host.rd(8'h0d + 8'(i), q);
			chk("reset read", q, {1'b1, e[i]});
		end
	endtask
	task automatic t_drive;
		u_aigh_host.wr(AIGH_OFS_DRV, 8'hff);
		settle();
		chk("drive pins", {HP_AC_COUPLED, OUT_FULL_DIFF, OUT_PSEUDO_DIFF}, 3'b110);
		u_aigh_host.wr(AIGH_OFS_DRV, 8'h08);
		@(negedge CLK) HEADSET_IN = 1'b1;
		u_aigh_host.rd(AIGH_OFS_DRV, q);
		chk("drive read", q, 9'h118);
		chk("drive pins", {HP_AC_COUPLED, OUT_FULL_DIFF, OUT_PSEUDO_DIFF}, 3'b001);
	endtask
	task automatic t_gain;
		logic [6:0] c [4] = '{7'h00, 7'h76, 7'h77, 7'h7f};
		logic [6:0] h [4] = '{7'h00, 7'h76, 7'h77, 7'h77};
		for (int i = 0; i < 4; i++) begin
			u_aigh_host.wr(AIGH_OFS_LGAIN, {1'b0, c[i]});
			u_aigh_host.wr(AIGH_OFS_RGAIN, {i[0], c[i]});
			settle();
			chk("left gain", {LEFT_AMP_MUTE, LEFT_AMP_GAIN}, {1'b0, h[i]});
			chk("right gain", {RIGHT_AMP_MUTE, RIGHT_AMP_GAIN}, {i[0], h[i]});
		end
	endtask
	function automatic logic [4:0] lvl(input logic [3:0] c);
		return (c > 4'h8) ? 5'h00 : {1'b1, c};
	endfunction
	task automatic t_level;
		logic [3:0] c [4] = '{4'h0, 4'h3, 4'h8, 4'hf};
		for (int i = 0; i < 4; i++) begin
			u_aigh_host.wr(AIGH_OFS_LMIX, {c[i], c[3 - i]});
			settle();
			chk("left level", SECOND_LEFT_INPUT_LVL, lvl(c[i]));
			chk("right level", SECOND_RIGHT_INPUT_LVL, lvl(c[3 - i]));
		end
	endtask
	task automatic end_of_test;
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge CLK);
		@(negedge CLK) NRST = 1'b1;
		t_reset();
		t_drive();
		t_gain();
		t_level();
		end_of_test();
	end
endmodule
